// *** sim/cca_host_model.sv ***
// host model: byte-wide register master for the accumulator
// assumes the bench calls its tasks and checks reg_rdata itself
`timescale 1ns/1ps
`include "cca_defines.svh"
module cca_host_model (
   input  wire logic core_clk,
   output logic [7:0] reg_addr,
   output logic [7:0] reg_wdata,
   output logic       reg_wr,
   output logic       reg_rd
);
   initial
   begin
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
   end
   // one access, strobe held for exactly one sampling edge
   task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
      @(posedge core_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= w;
      reg_rd <= !w;
      @(posedge core_clk);
      reg_wr <= 1'b0;
      reg_rd <= 1'b0;
   endtask
   // no coherent byte preset is possible while samples still land
   task automatic preset(input logic [31:0] v, input logic [7:0] ctl);
      acc(1'b1, `CCA_A_CTRL0, ctl & 8'hFB);
      for (int i = 0; i < 4; i++)
         acc(1'b1, `CCA_A_NET + 8'(i), v[8*i +: 8]);
   endtask
endmodule

// *** sim/coulomb_accumulator_logic_bench.sv ***
// self-checking bench for the accumulator top with a host model
// assumes QTR_CYC shortened to 4, so a quarter-ms tick is 4 cycles
`timescale 1ns/1ps
`include "cca_defines.svh"
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin mismatches++; \
   $display("ERROR t=%0t got %h exp %h", $time, g, e); end end
module coulomb_accumulator_logic_bench;
   logic               core_clk = 1'b0;
   logic               srst = 1'b1;
   logic signed [17:0] adc_data = 18'sh0ABCD;
   logic               conv_restart = 1'b0;
   logic [7:0]         reg_addr, reg_wdata, reg_rdata, e;
   logic               reg_wr, reg_rd, sample_take, current_ready;
   logic               rd_d = 1'b0;
   logic               en = 1'b0;
   logic [1:0]         mode = 2'h0;
   logic [7:0]         lfsr = 8'h56;
   logic [15:0]        mul = 16'h0000;
   logic signed [7:0]  ofs = 8'sh00;
   logic [3:0]         mk = 4'h0;
   logic signed [15:0] c;
   logic signed [63:0] s_net = 64'sh0;
   logic [63:0]        s_pos = 64'h0, s_neg = 64'h0;
   int                 mismatches = 0, tests_run = 0, n;
   logic [7:0]         q[$];

   always #5 core_clk = ~core_clk;

   cca_accum_top #(.QTR_CYC(4)) dut (
      .core_clk(core_clk), .srst(srst), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .adc_data(adc_data), .conv_restart(conv_restart),
      .reg_rdata(reg_rdata), .sample_take(sample_take),
      .current_ready(current_ready));
   cca_host_model host (.core_clk(core_clk), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd));

   function automatic logic [7:0] nx(input logic [7:0] x);
      return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
   endfunction

   // converter stand-in; mirrors what the totals should gain
   always @(posedge core_clk)
   begin
      if (sample_take)
      begin
         c = adc_data[17:2] + 16'(ofs);
         c = c & ~((16'h0001 << mk) - 16'h0001);
         if (mul != 16'h0000)
            c = 16'((32'(c) * {16'h0000, mul}) >> 16);
         if (en)
         begin
            s_net += 64'(c);
            if (c < 0)
               s_neg += 64'(-c);
            else
               s_pos += 64'(c);
         end
         lfsr <= nx(lfsr);
         adc_data <= mode == 2'h0 ? {2'b00, lfsr, 8'h00} :
                     mode == 2'h1 ? 18'sh3F000 : 18'sh0ABCD;
      end
   end

   always @(posedge core_clk)
   begin
      rd_d <= reg_rd;
      if (rd_d)
      begin
         e = q.pop_front();
         `CHK(reg_rdata, e)
      end
   end

   task automatic rd(input logic [7:0] a, input logic [7:0] x);
      q.push_back(x);
      host.acc(1'b0, a, 8'h00);
   endtask
   task automatic rd32(input logic [7:0] a, input logic [31:0] x);
      for (int i = 0; i < 4; i++)
         rd(a + 8'(i), x[8*i +: 8]);
   endtask
   task automatic smp(input int k);
      repeat (k) @(posedge core_clk iff sample_take);
   endtask
   task automatic stop_test;
      $display("tests_run=%0d mismatches=%0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   initial
   begin
      #100000;
      mismatches++;
      stop_test();
   end

   initial
   begin
      repeat (4) @(posedge core_clk);
      srst <= 1'b0;
      for (n = 0; n < 2000 && current_ready !== 1'b1; n++)
         @(negedge core_clk);
      `CHK(n >= 52 && n <= 64, 1'b1)
      rd32(`CCA_A_NET, 32'h0);
      rd(8'h30, 8'h00);
      $display("test reset done");
      smp(1);
      host.acc(1'b1, `CCA_A_CTRL0, 8'h04);
      en = 1'b1;
      smp(6);
      mode = 2'h1;
      smp(6);
      host.acc(1'b1, `CCA_A_CTRL0, 8'h00);
      en = 1'b0;
      mode = 2'h2;
      smp(12);
      rd32(`CCA_A_NET, 32'(s_net >>> 6));
      rd32(`CCA_A_CHG, 32'(s_pos >> 8));
      rd32(`CCA_A_DIS, 32'(s_neg >> 8));
      rd(`CCA_A_INST, 8'hF3);
      rd(`CCA_A_INST + 8'h01, 8'h2A);
      rd(`CCA_A_AVG, 8'hF3);
      rd(`CCA_A_AVG + 8'h01, 8'h2A);
      $display("test accumulate done");
      host.preset(32'h1234_5678, 8'h00);
      rd32(`CCA_A_NET, 32'h1234_5678);
      for (int b = 0; b < 3; b++)
      begin
         host.acc(1'b1, `CCA_A_CLR, 8'(1 << b));
         rd32(`CCA_A_NET + 8'(4 * b), 32'h0);
      end
      rd(`CCA_A_CLR, 8'h00);
      $display("test clear done");
      // codes 0..3 (code 0 unscaled, 1..3 scaled), then gain 25 unscaled
      for (int y = 0; y < 5; y++)
      begin
         host.acc(1'b1, `CCA_A_CTRL1, y == 4 ? 8'h01 : 8'h00);
         if (y == 4)
         begin
            host.acc(1'b1, `CCA_A_OFST, 8'h05);
            host.acc(1'b1, `CCA_A_MASK, 8'h04);
            ofs = 8'sh05;
            mk = 4'h4;
         end
         host.acc(1'b1, `CCA_A_CLR, 8'h07);
         s_net = 64'sh0;
         s_pos = 64'h0;
         mul = (y == 4 || y == 0) ? 16'h0000 :
               y == 3 ? 16'h1919 : 16'h3333;
         smp(1);
         host.acc(1'b1, `CCA_A_CTRL0, 8'(((y % 4 + y / 4) << 3) | 4));
         en = 1'b1;
         smp(8);
         host.acc(1'b1, `CCA_A_CTRL0, 8'h00);
         en = 1'b0;
         rd32(`CCA_A_NET, 32'(s_net >>> 6));
         rd32(`CCA_A_CHG, 32'(s_pos >> 8));
         $display("test gain %0d done", y);
      end
      rd(`CCA_A_INST, 8'hF3);
      // restart with oversampling 01: latency 6 ticks of 4 cycles
      host.acc(1'b1, `CCA_A_CTRL1, 8'h08);
      conv_restart <= 1'b1;
      @(posedge core_clk);
      conv_restart <= 1'b0;
      @(negedge core_clk);
      `CHK(current_ready, 1'b0)
      for (n = 0; n < 2000 && current_ready !== 1'b1; n++)
         @(negedge core_clk);
      `CHK(n >= 22 && n <= 28, 1'b1)
      $display("test restart done");
      repeat (3) @(posedge core_clk);
      stop_test();
   end
endmodule

// *** verilog/cca_accum_top.sv ***
// coulomb accumulator: timing, averaging, totals and byte registers
// assumes adc_data is the converter word, valid in sample_take cycles
`timescale 1ns/1ps
`include "cca_defines.svh"
module cca_accum_top #(
   parameter int QTR_CYC = `CCA_QTR_NS / `CCA_CLK_NS
) (
   input  wire logic               core_clk,
   input  wire logic               srst,
   input  wire logic [7:0]         reg_addr,
   input  wire logic [7:0]         reg_wdata,
   input  wire logic               reg_wr,
   input  wire logic               reg_rd,
   input  wire logic signed [17:0] adc_data,
   input  wire logic               conv_restart,
   output logic [7:0]              reg_rdata,
   output logic                    sample_take,
   output logic                    current_ready
);
   localparam int PW = $clog2(QTR_CYC + 1);
   localparam int NW = 32 + `CCA_FRAC_BITS;
   localparam int SW = NW + `CCA_SIDE_SHIFT;

   default clocking @(posedge core_clk);
   endclocking
   default disable iff (srst);

   if (QTR_CYC < 2)
   begin : g_chk
      $error("QTR_CYC must be at least 2");
   end

   // configuration
   logic [7:0]        ctrl0_reg;
   logic [7:0]        ctrl0_next;
   logic [7:0]        ctrl1_reg;
   logic [7:0]        ctrl1_next;
   logic signed [7:0] ofst_reg;
   logic signed [7:0] ofst_next;
   logic [3:0]        mask_reg;
   logic [3:0]        mask_next;
   logic              wr_ctl;
   logic              wr_clr;

   assign wr_ctl = reg_wr;
   assign wr_clr = reg_wr && reg_addr == `CCA_A_CLR;

   always_comb
   begin
      ctrl0_next = ctrl0_reg;
      ctrl1_next = ctrl1_reg;
      ofst_next  = ofst_reg;
      mask_next  = mask_reg;
      if (wr_ctl)
      begin
         unique case (reg_addr)
            `CCA_A_CTRL0: ctrl0_next = reg_wdata;
            `CCA_A_CTRL1: ctrl1_next = reg_wdata;
            `CCA_A_OFST:  ofst_next  = reg_wdata;
            `CCA_A_MASK:  mask_next  = reg_wdata[3:0];
            default:      ;
         endcase
      end
   end

   always_ff @(posedge core_clk)
   begin
      if (srst)
      begin
         ctrl0_reg <= `CCA_CTRL0_RST;
         ctrl1_reg <= `CCA_CTRL1_RST;
         ofst_reg  <= 8'h00;
         mask_reg  <= 4'h0;
      end
      else
      begin
         ctrl0_reg <= ctrl0_next;
         ctrl1_reg <= ctrl1_next;
         ofst_reg  <= ofst_next;
         mask_reg  <= mask_next;
      end
   end

   logic               acc_en;
   cca_pkg::cca_code2_t filt;
   cca_pkg::cca_code2_t oversampling_ratio_select;
   cca_pkg::cca_code2_t avg_sel;
   assign acc_en  = ctrl0_reg[`CCA_B_EN];
   assign filt    = ctrl0_reg[`CCA_F_FILT];
   assign oversampling_ratio_select     = ctrl1_reg[`CCA_F_OSR];
   assign avg_sel = ctrl1_reg[`CCA_F_AVG];

   // period and latency in quarter-ms ticks
   logic [23:0] per_tab;
   logic [35:0] lat_tab;
   logic [5:0]  per_sel;
   logic [8:0]  lat_sel;

   always_comb
   begin
      unique case (oversampling_ratio_select)
         2'h1:
         begin
            per_tab = `CCA_PER_OSR1;
            lat_tab = `CCA_LAT_OSR1;
         end
         2'h2:
         begin
            per_tab = `CCA_PER_OSR2;
            lat_tab = `CCA_LAT_OSR2;
         end
         2'h0, 2'h3:
         begin
            per_tab = `CCA_PER_OSR0;
            lat_tab = `CCA_LAT_OSR0;
         end
      endcase
   end

   assign per_sel = per_tab[int'(filt) * 6 +: 6];
   assign lat_sel = lat_tab[int'(filt) * 9 +: 9];

   // sample timing
   cca_pkg::cca_state_t state_reg;
   cca_pkg::cca_state_t state_next;
   logic [PW-1:0]       pre_reg;
   logic [PW-1:0]       pre_next;
   logic [8:0]          lat_reg;
   logic [8:0]          lat_next;
   logic [5:0]          per_reg;
   logic [5:0]          per_next;
   logic                take_next;
   logic                rdy_next;
   logic                qtr;

   always_comb
   begin
      qtr        = pre_reg == PW'(QTR_CYC - 1);
      pre_next   = qtr ? '0 : pre_reg + PW'(1);
      state_next = state_reg;
      lat_next   = lat_reg;
      per_next   = per_reg;
      take_next  = 1'b0;
      rdy_next   = current_ready;
      if (conv_restart)
      begin
         state_next = cca_pkg::CCA_WAIT;
         pre_next   = '0;
         lat_next   = 9'h000;
         per_next   = 6'h00;
         rdy_next   = 1'b0;
      end
      else if (qtr)
      begin
         unique case (state_reg)
            cca_pkg::CCA_WAIT:
            begin
               if (lat_reg >= lat_sel - 9'h001)
               begin
                  state_next = cca_pkg::CCA_RUN;
                  take_next  = 1'b1;
                  rdy_next   = 1'b1;
               end
               else
               begin
                  lat_next = lat_reg + 9'h001;
               end
            end
            cca_pkg::CCA_RUN:
            begin
               if (per_reg >= per_sel - 6'h01)
               begin
                  take_next = 1'b1;
                  per_next  = 6'h00;
               end
               else
               begin
                  per_next = per_reg + 6'h01;
               end
            end
         endcase
      end
   end

   always_ff @(posedge core_clk)
   begin
      if (srst)
      begin
         state_reg     <= cca_pkg::CCA_WAIT;
         pre_reg       <= '0;
         lat_reg       <= 9'h000;
         per_reg       <= 6'h00;
         sample_take   <= 1'b0;
         current_ready <= 1'b0;
      end
      else
      begin
         state_reg     <= state_next;
         pre_reg       <= pre_next;
         lat_reg       <= lat_next;
         per_reg       <= per_next;
         sample_take   <= take_next;
         current_ready <= rdy_next;
      end
   end

   // instantaneous current and block average
   logic signed [15:0] code;
   logic signed [15:0] inst_reg;
   logic signed [15:0] inst_next;
   logic signed [23:0] sum_reg;
   logic signed [23:0] sum_next;
   logic signed [23:0] tot;
   logic signed [23:0] avg_full;
   logic [6:0]         avg_cnt_reg;
   logic [6:0]         avg_cnt_next;
   logic [6:0]         cnt_max;
   logic [2:0]         avg_log;
   logic [15:0]        avg_reg;
   logic [15:0]        avg_next;
   logic [11:0]        log_tab;

   assign code    = adc_data[17:2];
   assign log_tab = `CCA_AVG_LOG;
   assign avg_log = log_tab[int'(avg_sel) * 3 +: 3];
   assign cnt_max = 7'((8'h01 << avg_log) - 8'h01);

   always_comb
   begin
      inst_next    = inst_reg;
      sum_next     = sum_reg;
      avg_cnt_next = avg_cnt_reg;
      avg_next     = avg_reg;
      tot          = sum_reg + 24'(code);
      avg_full     = tot >>> avg_log;
      if (sample_take)
      begin
         inst_next = code;
         if (avg_cnt_reg >= cnt_max)
         begin
            sum_next     = 24'h000000;
            avg_cnt_next = 7'h00;
            avg_next     = {avg_full[23], avg_full[23]
                            ? 15'(-avg_full) : avg_full[14:0]};
         end
         else
         begin
            sum_next     = tot;
            avg_cnt_next = avg_cnt_reg + 7'h01;
         end
      end
   end

   always_ff @(posedge core_clk)
   begin
      if (srst)
      begin
         inst_reg    <= 16'h0000;
         sum_reg     <= 24'h000000;
         avg_cnt_reg <= 7'h00;
         avg_reg     <= 16'h0000;
      end
      else
      begin
         inst_reg    <= inst_next;
         sum_reg     <= sum_next;
         avg_cnt_reg <= avg_cnt_next;
         avg_reg     <= avg_next;
      end
   end

   // conditioned sample, one cycle behind sample_take
   logic               acc_vld;
   logic signed [23:0] acc_val;

   cca_scaler u_scaler (
      .core_clk (core_clk),
      .srst     (srst),
      .in_vld   (sample_take),
      .code     (code),
      .offset   (ofst_reg),
      .mask_w   (mask_reg),
      .period   (per_sel),
      .gain     (ctrl0_reg[`CCA_F_GAIN]),
      .bypass   (ctrl1_reg[`CCA_B_BYP]),
      .out_vld  (acc_vld),
      .out_val  (acc_val)
   );

   // totals; internal units carry extra fraction below the visible bytes
   logic [NW-1:0] net_reg;
   logic [NW-1:0] net_next;
   logic [SW-1:0] chg_reg;
   logic [SW-1:0] chg_next;
   logic [SW-1:0] dis_reg;
   logic [SW-1:0] dis_next;
   logic [23:0]   mag;
   logic [7:0]    net_off;
   logic [7:0]    chg_off;
   logic [7:0]    dis_off;
   logic          add;
   logic [31:0]   net_vis;
   logic [31:0]   chg_vis;
   logic [31:0]   dis_vis;

   assign net_off = reg_addr - `CCA_A_NET;
   assign chg_off = reg_addr - `CCA_A_CHG;
   assign dis_off = reg_addr - `CCA_A_DIS;
   assign add     = acc_vld && acc_en;
   assign mag     = acc_val[23] ? 24'(-acc_val) : acc_val;
   assign net_vis = net_reg[`CCA_FRAC_BITS +: 32];
   assign chg_vis = chg_reg[`CCA_FRAC_BITS + `CCA_SIDE_SHIFT +: 32];
   assign dis_vis = dis_reg[`CCA_FRAC_BITS + `CCA_SIDE_SHIFT +: 32];

   always_comb
   begin
      net_next = net_reg;
      chg_next = chg_reg;
      dis_next = dis_reg;
      if (add)
      begin
         net_next = net_reg + NW'(acc_val);
         if (acc_val[23])
         begin
            dis_next = dis_reg + SW'(mag);
         end
         else
         begin
            chg_next = chg_reg + SW'(mag);
         end
      end
      // preset is meant for a stopped total; a write still wins
      if (reg_wr && net_off < 8'h04)
      begin
         net_next[`CCA_FRAC_BITS + 8 * int'(net_off[1:0]) +: 8] = reg_wdata;
      end
      if (wr_clr && reg_wdata[`CCA_B_CLR_NET])
      begin
         net_next = '0;
      end
      if (wr_clr && reg_wdata[`CCA_B_CLR_CHG])
      begin
         chg_next = '0;
      end
      if (wr_clr && reg_wdata[`CCA_B_CLR_DIS])
      begin
         dis_next = '0;
      end
   end

   always_ff @(posedge core_clk)
   begin
      if (srst)
      begin
         net_reg <= '0;
         chg_reg <= '0;
         dis_reg <= '0;
      end
      else
      begin
         net_reg <= net_next;
         chg_reg <= chg_next;
         dis_reg <= dis_next;
      end
   end

   // byte reads; multi-byte values are not snapshotted between bytes
   logic [7:0] rd_next;

   always_comb
   begin
      rd_next = reg_rdata;
      if (reg_rd)
      begin
         rd_next = 8'h00;
         if (net_off < 8'h04)
            rd_next = 8'(net_vis >> {net_off[1:0], 3'h0});
         else if (chg_off < 8'h04)
            rd_next = 8'(chg_vis >> {chg_off[1:0], 3'h0});
         else if (dis_off < 8'h04)
            rd_next = 8'(dis_vis >> {dis_off[1:0], 3'h0});
         else if (reg_addr == `CCA_A_CTRL0)
            rd_next = ctrl0_reg;
         else if (reg_addr == `CCA_A_CTRL1)
            rd_next = ctrl1_reg;
         else if (reg_addr == `CCA_A_OFST)
            rd_next = ofst_reg;
         else if (reg_addr == `CCA_A_MASK)
            rd_next = {4'h0, mask_reg};
         else if (reg_addr == `CCA_A_INST)
            rd_next = inst_reg[7:0];
         else if (reg_addr == `CCA_A_INST + 8'h01)
            rd_next = inst_reg[15:8];
         else if (reg_addr == `CCA_A_AVG)
            rd_next = avg_reg[7:0];
         else if (reg_addr == `CCA_A_AVG + 8'h01)
            rd_next = avg_reg[15:8];
      end
   end

   always_ff @(posedge core_clk)
   begin
      if (srst)
         reg_rdata <= 8'h00;
      else
         reg_rdata <= rd_next;
   end

   clr_net_a: assert property (
      wr_clr && reg_wdata[0] |=> net_reg == '0)
      else $error("net total not cleared");

   clr_side_a: assert property (
      wr_clr && reg_wdata[2:1] == 2'h3 |=> chg_reg == '0 && dis_reg == '0)
      else $error("side totals not cleared");

   hold_off_a: assert property (
      !acc_en && !reg_wr |=> $stable(net_reg) && $stable(chg_reg)
      && $stable(dis_reg))
      else $error("total moved while disabled");

   side_only_a: assert property (
      add && !acc_val[23] && !reg_wr |=> $stable(dis_reg)
      && chg_reg == $past(chg_reg) + SW'($past(mag)))
      else $error("charge sample reached discharge total");

   net_sum_a: assert property (
      add && !reg_wr |=> net_reg == $past(net_reg) + NW'($past(acc_val)))
      else $error("net total not summed");

   // scaler output is valid in the very cycle the register updates
   inst_full_a: assert property (
      sample_take |=> inst_reg == $past(code) && acc_vld)
      else $error("current register not updated in full");

   wait_quiet_a: assert property (
      state_reg == cca_pkg::CCA_WAIT && !qtr |=> !sample_take)
      else $error("sample taken inside latency");

   clr_read_a: assert property (
      reg_rd && reg_addr == `CCA_A_CLR |=> reg_rdata == 8'h00)
      else $error("clear register reads nonzero");

   avg_wrap_a: assert property (
      sample_take && avg_cnt_reg >= cnt_max |-> cnt_max == (avg_sel == 2'h0
      ? 7'h03 : avg_sel == 2'h1 ? 7'h0F : avg_sel == 2'h2 ? 7'h3F : 7'h7F)
      ##1 avg_cnt_reg == 7'h00)
      else $error("average block length wrong");

   clr_seen_c: cover property (wr_clr && reg_wdata[0] && add);
   avg_done_c: cover property (sample_take && avg_cnt_reg == cnt_max);
   dis_acc_c: cover property (add && acc_val[23]);
   ready_c: cover property ($rose(current_ready));
endmodule

// *** verilog/cca_defines.svh ***
// offsets, fields, reset values and timing for the coulomb accumulator
// assumes a byte-wide register port and core_clk at 100 MHz
//
// How it works
// - gain 25 divides samples by 5, gain 51 by 10.2, when scaling on
// - bypass bit at 01h: 0 scales samples, 1 accumulates raw samples
// - gain code 00 is 5, 01 and 10 are 25, 11 is 51
// - host may preset the net total with byte writes
// - enable low discards every accumulation update to all three totals
// - separate totals grow only on charging or only on discharging samples
// - charge and discharge totals sit two bits left of the net total
// - clear bits 0, 1, 2 at 02h clear net, charge, discharge totals
// - clears act regardless of enable and read back as zero
// - totals readable as four bytes from 17h, 1Bh and 1Fh
// - block-averaged current: sign plus 15-bit magnitude, per interval
// - average count codes 00..11 select 4, 16, 64, 128 samples
// - averaging interval is sample period times selected count
// - sample period set by oversampling and filter codes
// - one value per sample period updates current and the totals
// - no value until conversion latency passes after start or restart
// - converter word is 18 bits; 16-bit current is accumulated
// - configured count of low bits forced to zero before accumulation
// - masking touches only accumulation; current register stays full
// - manual offset at 0Bh is added before accumulation
// - filter field at 00h picks one of four characteristics
// - internal accumulator carries six more fractional bits than net
// - current register is a 16-bit two's complement value
// - accumulation runs only while enable bit at 00h is one
`ifndef CCA_DEFINES_SVH
`define CCA_DEFINES_SVH
`define CCA_A_CTRL0     8'h00
`define CCA_A_CTRL1     8'h01
`define CCA_A_CLR       8'h02
`define CCA_A_OFST      8'h0B
`define CCA_A_MASK      8'h0C
`define CCA_A_INST      8'h0D
`define CCA_A_AVG       8'h0F
`define CCA_A_NET       8'h17
`define CCA_A_CHG       8'h1B
`define CCA_A_DIS       8'h1F
`define CCA_B_EN        2
`define CCA_F_GAIN      4:3
`define CCA_F_FILT      6:5
`define CCA_B_BYP       0
`define CCA_F_AVG       2:1
`define CCA_F_OSR       4:3
`define CCA_B_CLR_NET   0
`define CCA_B_CLR_CHG   1
`define CCA_B_CLR_DIS   2
`define CCA_CTRL0_RST   8'h00
`define CCA_CTRL1_RST   8'h00
`define CCA_FRAC_BITS   6
`define CCA_SIDE_SHIFT  2
`define CCA_CLK_NS      10
`define CCA_QTR_NS      250000
`define CCA_PER_OSR0    {6'h20, 6'h08, 6'h04, 6'h01}
`define CCA_PER_OSR1    {6'h08, 6'h02, 6'h01, 6'h01}
`define CCA_PER_OSR2    {6'h02, 6'h01, 6'h01, 6'h01}
`define CCA_LAT_OSR0    {9'h182, 9'h062, 9'h032, 9'h00E}
`define CCA_LAT_OSR1    {9'h062, 9'h01A, 9'h00E, 9'h006}
`define CCA_LAT_OSR2    {9'h01A, 9'h00A, 9'h006, 9'h006}
`define CCA_AVG_LOG     {3'h7, 3'h6, 3'h4, 3'h2}
`define CCA_DIV5_MUL    16'h3333
`define CCA_DIV10P2_MUL 16'h1919
`define CCA_MUL_SHIFT   16
`endif

// *** verilog/cca_pkg.sv ***
// types shared by the coulomb accumulator files
// assumes nothing beyond the constants header
package cca_pkg;
   typedef enum logic {
      CCA_WAIT = 1'b0,
      CCA_RUN  = 1'b1
   } cca_state_t;
   typedef logic [1:0] cca_code2_t;
endpackage

// *** verilog/cca_scaler.sv ***
// sample conditioning: offset, low-bit mask, period weight, gain scaling
// assumes in_vld is a one-cycle pulse with its inputs steady that cycle
`timescale 1ns/1ps
`include "cca_defines.svh"
module cca_scaler (
   input  wire logic               core_clk,
   input  wire logic               srst,
   input  wire logic               in_vld,
   input  wire logic signed [15:0] code,
   input  wire logic signed [7:0]  offset,
   input  wire logic [3:0]         mask_w,
   input  wire logic [5:0]         period,
   input  cca_pkg::cca_code2_t     gain,
   input  wire logic               bypass,
   output logic                    out_vld,
   output logic signed [23:0]      out_val
);
   logic signed [16:0] shifted;
   logic signed [16:0] lowmask;
   logic signed [16:0] masked;
   logic signed [23:0] timed;
   logic signed [40:0] prod;
   logic signed [16:0] mul;
   logic signed [23:0] val_next;
   logic signed [23:0] timed_reg;

   always_comb
   begin
      shifted = 17'(code) + 17'(offset);
      lowmask = 17'((17'h00001 << mask_w) - 17'h00001);
      masked  = shifted & ~lowmask;
      // weight by period so totals stay in quarter-ms units
      timed = 24'(masked) * 24'($signed({1'b0, period}));
      mul = $signed({1'b0, (gain == 2'h3) ? `CCA_DIV10P2_MUL
                                           : `CCA_DIV5_MUL});
      prod = 41'(timed) * 41'(mul);
      val_next = timed;
      if (!bypass && gain != 2'h0)
      begin
         val_next = 24'(prod >>> `CCA_MUL_SHIFT);
      end
   end

   always_ff @(posedge core_clk)
   begin
      if (srst)
      begin
         out_vld   <= 1'b0;
         out_val   <= 24'h000000;
         timed_reg <= 24'h000000;
      end
      else
      begin
         out_vld   <= in_vld;
         out_val   <= val_next;
         timed_reg <= timed;
      end
   end

   div_five_a: assert property (@(posedge core_clk) disable iff (srst)
      in_vld && !bypass && (gain == 2'h1 || gain == 2'h2) |=>
      (timed_reg - 24'(out_val * 5) >= 0) &&
      (timed_reg - 24'(out_val * 5) <= 8))
      else $error("divide by five result out of range");

   mask_low_a: assert property (@(posedge core_clk) disable iff (srst)
      in_vld && bypass && period == 6'h01 |=>
      (out_val[16:0] & $past(lowmask)) == 17'h00000)
      else $error("masked low bits reached the totals");
endmodule
